// ==== core/supervisor_defs.vh ====
// Shared constants of the core regulator mode and fault supervisor
`ifndef SUPERVISOR_DEFS_VH
`define SUPERVISOR_DEFS_VH

// Operating modes
`define MODE_ACTIVE        2'h0
`define MODE_DEEP          2'h1
`define MODE_DEEPER        2'h2

// Regulation target selection
`define TARGET_BOOT        2'h0
`define TARGET_VID         2'h1
`define TARGET_DEEP        2'h2
`define TARGET_DEEPER      2'h3

// Timing
`define CLK_PERIOD_NS      10
`define BOOT_DELAY_MS      10
// 10 ms of 10 ns cycles, sized to fit the 24-bit delay counter
`define BOOT_DELAY_CYCLES  24'h0F_4240
`define PG_TIMER_DEFAULT   24'h01_0000
`define MASK_DEFAULT       8'h40

// Fault windows in phase cycles
`define UV_WINDOW          8'h21
`define OC_WINDOW          8'h20

// Reset values and counter width
`define VID_RESET          6'h00
`define CNT_WIDTH          24

`endif

// ==== core/fault_window_counter.v ====
// Phase-cycle fault window counter, consecutive or up/down
`timescale 1ns/1ps
`include "supervisor_defs.vh"

module fault_window_counter #(
  parameter [7:0] LIMIT  = `OC_WINDOW,
  parameter       UPDOWN = 1
) (
  input  wire       core_clk,
  input  wire       rst,
  input  wire       clear,
  input  wire       tick,
  input  wire       cond,
  output wire       trip
);

  reg [7:0] count_r;

  always @(posedge core_clk) begin
    if (rst || clear) begin
      count_r <= 8'h00;
    end else if (tick) begin
      if (cond) begin
        if (count_r != LIMIT)
          count_r <= count_r + 8'h01;
      end else if (UPDOWN != 0) begin
        // Up/down: brief dips in the fault only slowly forgive it
        if (count_r != 8'h00)
          count_r <= count_r - 8'h01;
      end else begin
        count_r <= 8'h00;
      end
    end
  end

  assign trip = (count_r >= LIMIT);

endmodule

// ==== core/core_regulator_mode_fault_supervisor.v ====
// Start-up, sleep mode, power-good and fault latch supervisor
// Contract
// - Boot setpoint, then 10ms delay, then VOLTAGE_ID_CODE; code selects VOLTAGE_ID_CODE when the delay starts
// - Both sleep inputs low selects deep setpoint
// - Deeper input high, deep low selects deeper
// - Deep high, deeper low: active, follow VOLTAGE_ID_CODE
// - Sleep modes use single channel when tied
// - Overcurrent when average current reaches threshold
// - Overvoltage or undervoltage pulls power good low
// - Power good is input until externals release
// - On sink detect capture VOLTAGE_ID_CODE as target
// - Power good low until internal timer expires
// - Mask power good during VOLTAGE_ID_CODE, mode changes
// - Overvoltage latches, forces PWM low, low-sides on
// - Below 102% both switches off, cycling repeats
// - Overvoltage latch cleared only by power reset
// - Overvoltage threshold 112% of mode setpoint
// - Under 84% over 32 phase cycles latches; code latches after 33 consecutive phase cycles
// - Undervoltage latch cleared by reset or enable
// - Overcurrent 32 phase-cycle counter then latch off
// - Overcurrent clearing within window continues regulation
`timescale 1ns/1ps
`include "supervisor_defs.vh"

module core_regulator_mode_fault_supervisor #(
  parameter [23:0] BOOT_DELAY_CYCLES = `BOOT_DELAY_CYCLES,
  parameter [23:0] PG_TIMER_CYCLES   = `PG_TIMER_DEFAULT,
  parameter [7:0]  MASK_CYCLES       = `MASK_DEFAULT
) (
  input  wire       core_clk,
  input  wire       rst,
  input  wire       enable,
  input  wire       deep_sleep_select_n,
  input  wire       deeper_sleep_select,
  input  wire       phase_count_select,
  input  wire [5:0] voltage_id_code,
  input  wire       phase_clk,
  input  wire       sink_current_detect,
  input  wire       ov_compare,
  input  wire       ov_release_compare,
  input  wire       uv_compare,
  input  wire       oc_compare,
  input  wire       power_good_in,
  output reg        power_good_out,
  output reg        power_good_oe,
  output reg        system_power_good_wired_or,
  output reg  [1:0] target_select,
  output reg  [5:0] target_vid,
  output reg  [1:0] mode,
  output reg        single_channel,
  output reg        converter_enable,
  output reg        pwm_force_low,
  output reg        low_side_on,
  output reg        gate_drive_off,
  output reg        overvoltage_protect,
  output reg        uv_latched,
  output reg        oc_latched
);

  localparam [2:0] ST_OFF     = 3'h0;
  localparam [2:0] ST_BOOT    = 3'h1;
  localparam [2:0] ST_DELAY   = 3'h2;
  localparam [2:0] ST_RUN     = 3'h3;
  localparam [2:0] ST_LATCHED = 3'h4;

  localparam integer SYNC_W = 17;
  // Deep-sleep request idles high; zero here would fake a deep entry
  localparam [SYNC_W-1:0] SYNC_IDLE = 17'h0_0002;

  // Mode from the two system sleep lines; deeper wins when both high
  function [1:0] mode_of;
    input ds_n;
    input drs;
    begin
      if (drs)
        mode_of = `MODE_DEEPER;
      else if (!ds_n)
        mode_of = `MODE_DEEP;
      else
        mode_of = `MODE_ACTIVE;
    end
  endfunction

  function [1:0] target_of;
    input [1:0] m;
    begin
      case (m)
        `MODE_DEEP:   target_of = `TARGET_DEEP;
        `MODE_DEEPER: target_of = `TARGET_DEEPER;
        default:      target_of = `TARGET_VID;
      endcase
    end
  endfunction

  reg  [SYNC_W-1:0] sync1_r;
  reg  [SYNC_W-1:0] sync2_r;
  wire [SYNC_W-1:0] raw_in;

  assign raw_in = {voltage_id_code, power_good_in, oc_compare, uv_compare,
                   ov_release_compare, ov_compare, sink_current_detect, phase_clk,
                   phase_count_select, deeper_sleep_select, deep_sleep_select_n, enable};

  // Two-stage synchronisers for all pin and comparator inputs
  always @(posedge core_clk) begin
    if (rst) begin
      sync1_r <= SYNC_IDLE;
      sync2_r <= SYNC_IDLE;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  wire       en_s    = sync2_r[0];
  wire       ds_n_s  = sync2_r[1];
  wire       drs_s   = sync2_r[2];
  wire       pcs_s   = sync2_r[3];
  wire       phc_s   = sync2_r[4];
  wire       sink_s  = sync2_r[5];
  wire       ov_s    = sync2_r[6];
  wire       ovrel_s = sync2_r[7];
  wire       uv_s    = sync2_r[8];
  wire       oc_s    = sync2_r[9];
  wire       pgin_s  = sync2_r[10];
  wire [5:0] vid_s   = sync2_r[16:11];

  reg        en_d_r;
  reg        phc_d_r;
  reg  [1:0] mode_r;
  reg  [5:0] vid_d_r;
  reg  [2:0] state_r;
  reg  [2:0] state_nxt;
  reg [23:0] delay_cnt_r;
  reg [23:0] pg_timer_r;
  reg        pg_expired_r;
  reg  [7:0] mask_cnt_r;
  reg        ov_latch_r;
  reg        uv_latch_r;
  reg        oc_latch_r;

  wire       en_toggle  = en_s ^ en_d_r;
  wire       phase_tick = phc_s & ~phc_d_r;
  wire [1:0] mode_nxt   = mode_of(ds_n_s, drs_s);
  wire       running    = (state_r == ST_RUN);
  wire       uv_trip;
  wire       oc_trip;
  wire       mode_change = running && (mode_nxt != mode_r);
  wire       vid_change  = running && (mode_r == `MODE_ACTIVE) && (vid_s != vid_d_r);
  wire       masked      = (mask_cnt_r != 8'h00) || mode_change || vid_change;
  wire       latched_any = ov_latch_r | uv_latch_r | oc_latch_r;

  always @(posedge core_clk) begin
    if (rst) begin
      en_d_r  <= 1'b0;
      phc_d_r <= 1'b0;
      mode_r  <= `MODE_ACTIVE;
      vid_d_r <= `VID_RESET;
    end else begin
      en_d_r  <= en_s;
      phc_d_r <= phc_s;
      mode_r  <= mode_nxt;
      vid_d_r <= vid_s;
    end
  end

  // Undervoltage must persist for 33 consecutive phase ticks
  fault_window_counter #(
    .LIMIT  (`UV_WINDOW),
    .UPDOWN (0)
  ) uv_window (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (!running),
    .tick     (phase_tick),
    .cond     (uv_s),
    .trip     (uv_trip)
  );

  // Overcurrent integrates up and down over 32 phase ticks
  fault_window_counter #(
    .LIMIT  (`OC_WINDOW),
    .UPDOWN (1)
  ) oc_window (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (!running),
    .tick     (phase_tick),
    .cond     (oc_s),
    .trip     (oc_trip)
  );

  // Sequencer
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (en_s)
          state_nxt = ST_BOOT;
      end
      ST_BOOT: begin
        if (sink_s)
          state_nxt = ST_DELAY;
      end
      ST_DELAY: begin
        if (delay_cnt_r >= BOOT_DELAY_CYCLES)
          state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (uv_trip || oc_trip)
          state_nxt = ST_LATCHED;
      end
      ST_LATCHED: begin
        if (en_toggle)
          state_nxt = ST_OFF;
      end
      default: state_nxt = ST_OFF;
    endcase
    if (!en_s && state_r != ST_LATCHED)
      state_nxt = ST_OFF;
  end

  always @(posedge core_clk) begin
    if (rst) begin
      state_r      <= ST_OFF;
      delay_cnt_r  <= 24'h00_0000;
      pg_timer_r   <= 24'h00_0000;
      pg_expired_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_DELAY)
        delay_cnt_r <= delay_cnt_r + 24'h00_0001;
      else
        delay_cnt_r <= 24'h00_0000;
      // Timer runs from sink detection; restarting it on exit is deliberate
      if (state_r == ST_DELAY || running) begin
        if (pg_timer_r >= PG_TIMER_CYCLES)
          pg_expired_r <= 1'b1;
        else
          pg_timer_r <= pg_timer_r + 24'h00_0001;
      end else begin
        pg_timer_r   <= 24'h00_0000;
        pg_expired_r <= 1'b0;
      end
    end
  end

  // Fault latches; a trip in the toggle cycle still latches
  always @(posedge core_clk) begin
    if (rst) begin
      ov_latch_r <= 1'b0;
      uv_latch_r <= 1'b0;
      oc_latch_r <= 1'b0;
    end else begin
      if (ov_s && state_r != ST_OFF)
        ov_latch_r <= 1'b1;
      if (running && uv_trip)
        uv_latch_r <= 1'b1;
      else if (en_toggle)
        uv_latch_r <= 1'b0;
      if (running && oc_trip)
        oc_latch_r <= 1'b1;
      else if (en_toggle)
        oc_latch_r <= 1'b0;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      mask_cnt_r <= 8'h00;
    end else if (mode_change || vid_change) begin
      mask_cnt_r <= MASK_CYCLES;
    end else if (mask_cnt_r != 8'h00) begin
      mask_cnt_r <= mask_cnt_r - 8'h01;
    end
  end

  // Target selection and captured identification code
  always @(posedge core_clk) begin
    if (rst) begin
      target_select <= `TARGET_BOOT;
      target_vid    <= `VID_RESET;
    end else begin
      case (state_r)
        ST_BOOT: begin
          target_select <= `TARGET_BOOT;
          if (sink_s)
            target_vid <= vid_s;
        end
        ST_DELAY: begin
          target_select <= `TARGET_VID;
        end
        ST_RUN: begin
          target_select <= target_of(mode_r);
          if (mode_r == `MODE_ACTIVE)
            target_vid <= vid_s;
        end
        default: begin
          target_select <= `TARGET_BOOT;
        end
      endcase
    end
  end

  // Open-drain power good: enable high means the pin is pulled low
  always @(posedge core_clk) begin
    if (rst) begin
      power_good_out             <= 1'b0;
      power_good_oe              <= 1'b1;
      system_power_good_wired_or <= 1'b0;
    end else begin
      power_good_out             <= 1'b0;
      system_power_good_wired_or <= pgin_s;
      if (!running || latched_any || uv_trip || oc_trip)
        power_good_oe <= 1'b1;
      else if (!masked)
        power_good_oe <= !pg_expired_r || ov_s || uv_s;
    end
  end

  // Gate drive control; overvoltage chatter between low and off by design
  always @(posedge core_clk) begin
    if (rst) begin
      mode                <= `MODE_ACTIVE;
      single_channel      <= 1'b0;
      converter_enable    <= 1'b0;
      pwm_force_low       <= 1'b0;
      low_side_on         <= 1'b0;
      gate_drive_off      <= 1'b1;
      overvoltage_protect <= 1'b0;
      uv_latched          <= 1'b0;
      oc_latched          <= 1'b0;
    end else begin
      mode                <= mode_r;
      single_channel      <= !pcs_s;
      overvoltage_protect <= ov_latch_r;
      uv_latched          <= uv_latch_r;
      oc_latched          <= oc_latch_r;
      if (ov_latch_r || ov_s) begin
        converter_enable <= 1'b0;
        pwm_force_low    <= 1'b1;
        low_side_on      <= ovrel_s || ov_s;
        gate_drive_off   <= !(ovrel_s || ov_s);
      end else if (uv_latch_r || oc_latch_r || state_r == ST_OFF
                   || state_r == ST_LATCHED) begin
        converter_enable <= 1'b0;
        pwm_force_low    <= 1'b1;
        low_side_on      <= 1'b0;
        gate_drive_off   <= 1'b1;
      end else begin
        converter_enable <= 1'b1;
        pwm_force_low    <= 1'b0;
        low_side_on      <= 1'b0;
        gate_drive_off   <= 1'b0;
      end
    end
  end

endmodule

// ==== verif/supervisor_monitor.sv ====
// Checker of supervisor fault latches, modes and power good
`timescale 1ns/1ps
`include "supervisor_defs.vh"
module supervisor_monitor (
  input wire       core_clk,
  input wire       rst,
  input wire       phase_count_select,
  input wire       power_good_out,
  input wire       power_good_oe,
  input wire [1:0] target_select,
  input wire [1:0] mode,
  input wire       single_channel,
  input wire       converter_enable,
  input wire       pwm_force_low,
  input wire       low_side_on,
  input wire       gate_drive_off,
  input wire       overvoltage_protect,
  input wire       uv_latched,
  input wire       oc_latched
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Mode step taken while power good is released
  sequence s_mode_move;
    $changed(mode) && converter_enable && !power_good_oe;
  endsequence
  sequence s_pcs_low;
    !phase_count_select [*6];
  endsequence
  a_ov_forces_low: assert property (
    overvoltage_protect [*2] |-> pwm_force_low && !converter_enable)
    else $error("ov latch without forced low drive");
  a_ov_both_off: assert property (
    overvoltage_protect && gate_drive_off |-> !low_side_on && pwm_force_low)
    else $error("ov off phase with low side on");
  a_ov_latch_holds: assert property (
    overvoltage_protect |=> overvoltage_protect)
    else $error("ov latch cleared without reset");
  a_uv_pg_low: assert property (
    uv_latched [*2] |-> power_good_oe && !converter_enable)
    else $error("uv latch with converter running");
  a_oc_pg_low: assert property (
    oc_latched [*2] |-> power_good_oe && gate_drive_off)
    else $error("oc latch with power good released");
  a_pg_open_drain: assert property (
    !power_good_out)
    else $error("power good driven high");
  a_deep_target: assert property (
    mode == `MODE_DEEP && $stable(mode) |-> target_select == `TARGET_DEEP)
    else $error("deep mode with wrong target");
  a_deeper_target: assert property (
    mode == `MODE_DEEPER && $stable(mode) |-> target_select == `TARGET_DEEPER)
    else $error("deeper mode with wrong target");
  a_single_chan: assert property (
    s_pcs_low |-> single_channel)
    else $error("single channel not taken");
  a_pg_mask_hold: assert property (
    s_mode_move |=> !power_good_oe [*4])
    else $error("power good moved during mask");
endmodule

bind core_regulator_mode_fault_supervisor supervisor_monitor mon_u (
  .core_clk, .rst, .phase_count_select, .power_good_out, .power_good_oe,
  .target_select, .mode, .single_channel, .converter_enable, .pwm_force_low,
  .low_side_on, .gate_drive_off, .overvoltage_protect, .uv_latched, .oc_latched
);

// ==== verif/pm_partner.sv ====
// Companion regulator power-good model on the shared open-drain pin
`timescale 1ns/1ps
module pm_partner (
  input  wire core_clk,
  input  wire release_req,
  input  wire dev_pull,
  output reg  ext_pull_low,
  output wire sink_seen
);
  initial ext_pull_low = 1'h1;
  // Externals hold the wired-OR low until they regulate
  always @(posedge core_clk) begin
    ext_pull_low <= !release_req;
  end
  // Sink current needs the pin released and the device pulling
  assign sink_seen = !ext_pull_low && dev_pull;
endmodule

// ==== verif/core_regulator_mode_fault_supervisor_test.sv ====
// Bench for supervisor start-up, modes and fault latches
`timescale 1ns/1ps
`include "supervisor_defs.vh"
module core_regulator_mode_fault_supervisor_test;
  logic       core_clk = 0, rst = 1, enable = 0, phase_clk = 0, release_req = 0;
  logic       deep_sleep_select_n = 1, deeper_sleep_select = 0, phase_count_select = 1;
  logic       ov_compare = 0, ov_release_compare = 0, uv_compare = 0, oc_compare = 0;
  logic [5:0] voltage_id_code = 6'h15;
  logic       power_good_out, power_good_oe, system_power_good_wired_or, single_channel;
  logic       converter_enable, pwm_force_low, low_side_on, gate_drive_off;
  logic       overvoltage_protect, uv_latched, oc_latched, ext_pull_low, sink_current_detect;
  logic [1:0] target_select, mode;
  logic [5:0] target_vid;
  int         fail_count = 0, tests_run = 0, cycles = 0;
  logic [1:0] pin_t [5] = '{2'h2, 2'h0, 2'h1, 2'h3, 2'h2};
  logic [1:0] md_t [5] = '{`MODE_ACTIVE, `MODE_DEEP, `MODE_DEEPER, `MODE_DEEPER, `MODE_ACTIVE};
  logic [1:0] tg_t [5] = '{`TARGET_VID, `TARGET_DEEP, `TARGET_DEEPER, `TARGET_DEEPER, `TARGET_VID};
  // Pulled-up wired-OR of both open-drain parties
  wire        power_good_in = !(ext_pull_low | power_good_oe);

  always #5 core_clk = !core_clk;

  core_regulator_mode_fault_supervisor #(
    .BOOT_DELAY_CYCLES(24'h00_0032),
    .PG_TIMER_CYCLES  (24'h00_0014),
    .MASK_CYCLES      (8'h08)
  ) dut_u (
    .core_clk, .rst, .enable, .deep_sleep_select_n, .deeper_sleep_select,
    .phase_count_select, .voltage_id_code, .phase_clk, .sink_current_detect,
    .ov_compare, .ov_release_compare, .uv_compare, .oc_compare, .power_good_in,
    .power_good_out, .power_good_oe, .system_power_good_wired_or, .target_select,
    .target_vid, .mode, .single_channel, .converter_enable, .pwm_force_low,
    .low_side_on, .gate_drive_off, .overvoltage_protect, .uv_latched, .oc_latched
  );

  pm_partner partner_u (
    .core_clk, .release_req, .dev_pull(power_good_oe), .ext_pull_low,
    .sink_seen(sink_current_detect)
  );

  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Ticks wide enough for the two-stage input sync
  task tick(input int n);
    repeat (n) begin
      phase_clk <= 1'h1;
      cyc(3);
      phase_clk <= 1'h0;
      cyc(3);
    end
    cyc(4);
  endtask

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    @(negedge core_clk);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
    @(posedge core_clk);
  endtask

  // pg_low: the overvoltage latch survives the restart and keeps the pin pulled
  task boot(input logic pg_low);
    enable <= 1'h1;
    cyc(12);
    chk("target_select", `TARGET_BOOT, target_select);
    release_req <= 1'h1;
    cyc(12);
    chk("target_vid", voltage_id_code, target_vid);
    chk("power_good_oe", 1'h1, power_good_oe);
    cyc(90);
    chk("power_good_oe", pg_low, power_good_oe);
    chk("target_select", `TARGET_VID, target_select);
    chk("system_power_good_wired_or", !pg_low, system_power_good_wired_or);
  endtask

  // Enable edge restarts the whole start-up
  task retog(input logic pg_low);
    enable <= 1'h0;
    release_req <= 1'h0;
    cyc(8);
    boot(pg_low);
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      fail_count++;
      finish_test;
    end
  end

  task finish_test;
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    cyc(6);
    rst <= 1'h0;
    boot(1'h0);
    $display("test start-up done");
    for (int i = 0; i < 5; i++) begin
      {deep_sleep_select_n, deeper_sleep_select} <= pin_t[i];
      cyc(20);
      chk("mode", md_t[i], mode);
      chk("target_select", tg_t[i], target_select);
    end
    voltage_id_code <= 6'h2a;
    phase_count_select <= 1'h0;
    cyc(12);
    chk("target_vid", 6'h2a, target_vid);
    chk("single_channel", 1'h1, single_channel);
    phase_count_select <= 1'h1;
    $display("test modes done");
    uv_compare <= 1'h1;
    cyc(6);
    chk("power_good_oe", 1'h1, power_good_oe);
    uv_compare <= 1'h0;
    cyc(6);
    chk("power_good_oe", 1'h0, power_good_oe);
    oc_compare <= 1'h1;
    cyc(3);
    tick(10);
    oc_compare <= 1'h0;
    cyc(3);
    tick(12);
    chk("oc_latched", 1'h0, oc_latched);
    oc_compare <= 1'h1;
    cyc(3);
    tick(31);
    chk("oc_latched", 1'h0, oc_latched);
    tick(2);
    chk("oc_latched", 1'h1, oc_latched);
    chk("power_good_oe", 1'h1, power_good_oe);
    oc_compare <= 1'h0;
    retog(1'h0);
    chk("oc_latched", 1'h0, oc_latched);
    $display("test overcurrent done");
    uv_compare <= 1'h1;
    cyc(3);
    tick(32);
    chk("uv_latched", 1'h0, uv_latched);
    tick(1);
    chk("uv_latched", 1'h1, uv_latched);
    uv_compare <= 1'h0;
    retog(1'h0);
    chk("uv_latched", 1'h0, uv_latched);
    $display("test undervoltage done");
    ov_compare <= 1'h1;
    cyc(6);
    chk("overvoltage_protect", 1'h1, overvoltage_protect);
    chk("low_side_on", 1'h1, low_side_on);
    ov_compare <= 1'h0;
    cyc(6);
    chk("gate_drive_off", 1'h1, gate_drive_off);
    retog(1'h1);
    chk("overvoltage_protect", 1'h1, overvoltage_protect);
    rst <= 1'h1;
    cyc(6);
    rst <= 1'h0;
    cyc(2);
    chk("overvoltage_protect", 1'h0, overvoltage_protect);
    $display("test overvoltage done");
    finish_test;
  end
endmodule
